// *** hw/pot_dev.sv ***
// Slave end of the two-wire link for the dual potentiometer
//
// Summary of operation
// - Low protect pin blocks nonvolatile register writes
// - Data changes only while clock low
// - Master opens every command with start
// - Watch for start; ignore bus until then
// - Master ends every transaction with stop
// - Receiver pulls data low on ninth clock; host leaves data released on the ninth clock of a read byte
// - Acknowledge address, command and data byte
// - Master sends address; upper nibble is type
// - Lower address nibble must match straps
// - Six-bit wiper decodes to one-hot tap
// - Wiper written directly or copied from register
// - Stop after nonvolatile write starts write cycle
// - No address acknowledge while write busy
// - Master polls address until acknowledged; host polls once per request, bench waits on nv_busy then polls once
// - Master makes clock; device only slave
// - Instruction byte: code, register, potentiometer
`timescale 1ns/10ps
module pot_dev
   import pot_link_pkg::*;
#(
   parameter int WRITE_CYCLES = WR_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   pot_link_if.dev_end link,
   input wire logic [3:0] board_address_straps,
   input wire logic write_protect_b,
   output logic [63:0] tap_sel_0,
   output logic [63:0] tap_sel_1,
   output logic nv_busy
);

   if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << BUSY_W)) begin : g_chk
      $error("WRITE_CYCLES out of range");
   end

   localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES);

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      logic [1:0] wp_s;
      logic [7:0] strap_s;
      dev_state_e st;
      byte_e by;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] instr;
      logic ack_seen;
      logic drv;
      logic [1:0] pend_pot;
      logic [1:0] pend_reg;
      logic [1:0][5:0] pend_val;
      logic [BUSY_W-1:0] busy_cnt;
      logic [1:0][5:0] wiper_position_register;
      logic [1:0][3:0][5:0] data_reg;
      logic [1:0][63:0] tap;
   } dev_s;

   dev_s r_ff;
   dev_s nxt_r;

   function automatic logic op_valid(input logic [3:0] op);
      case (op)
         OP_RD_WCR, OP_WR_WCR, OP_RD_DR, OP_WR_DR, OP_XFR_D2W, OP_XFR_W2D,
         OP_GXFR_D2W, OP_GXFR_W2D, OP_STEP: op_valid = 1'b1;
         default: op_valid = 1'b0;
      endcase
   endfunction

   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_ev;
      logic stop_ev;
      logic [3:0] op;
      logic [1:0] rsel;
      logic pot;
      logic [5:0] val;
      nxt_r = r_ff;
      scl_rise = r_ff.scl_s[1] & ~r_ff.scl_d;
      scl_fall = ~r_ff.scl_s[1] & r_ff.scl_d;
      start_ev = r_ff.scl_s[1] & r_ff.scl_d & r_ff.sda_d & ~r_ff.sda_s[1];
      stop_ev = r_ff.scl_s[1] & r_ff.scl_d & ~r_ff.sda_d & r_ff.sda_s[1];
      op = r_ff.instr[OP_HI:OP_LO];
      rsel = r_ff.instr[REG_HI:REG_LO];
      pot = r_ff.instr[POT_BIT];
      val = WIPER_MIN;

      // First stages only feed second stages; edges use second and third
      nxt_r.scl_s = {r_ff.scl_s[0], link.scl};
      nxt_r.sda_s = {r_ff.sda_s[0], link.sda};
      nxt_r.scl_d = r_ff.scl_s[1];
      nxt_r.sda_d = r_ff.sda_s[1];
      nxt_r.wp_s = {r_ff.wp_s[0], write_protect_b};
      nxt_r.strap_s = {r_ff.strap_s[3:0], board_address_straps};

      if (r_ff.busy_cnt != '0) begin
         nxt_r.busy_cnt = r_ff.busy_cnt - BUSY_W'(1);
      end

      if (start_ev) begin
         // A start restarts the receiver from any state
         nxt_r.st = DS_RX;
         nxt_r.by = BY_ADDR;
         nxt_r.cnt = '0;
         nxt_r.drv = 1'b0;
         nxt_r.ack_seen = 1'b0;
      end else if (stop_ev) begin
         nxt_r.st = DS_IDLE;
         nxt_r.drv = 1'b0;
         if (r_ff.pend_pot != 2'b00) begin
            nxt_r.pend_pot = 2'b00;
            // Protected writes are dropped and start no write cycle
            if (r_ff.wp_s[1]) begin
               for (int p = 0; p < 2; p++) begin
                  if (r_ff.pend_pot[p]) begin
                     nxt_r.data_reg[p][r_ff.pend_reg] = r_ff.pend_val[p];
                  end
               end
               nxt_r.busy_cnt = BUSY_LOAD;
            end
         end
      end else begin
         case (r_ff.st)
            DS_IDLE: begin
               nxt_r.drv = 1'b0;
            end
            DS_RX: begin
               if (scl_rise) begin
                  nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s[1]};
                  nxt_r.cnt = r_ff.cnt + 4'h1;
               end else if (scl_fall && r_ff.cnt == BIT_LAST) begin
                  nxt_r.st = DS_ACK;
                  nxt_r.drv = 1'b1;
                  nxt_r.ack_seen = 1'b0;
                  case (r_ff.by)
                     BY_ADDR: begin
                        if (r_ff.sh[ID_HI:ID_LO] != DEV_TYPE_ID ||
                            r_ff.sh[ADR_HI:ADR_LO] != r_ff.strap_s[7:4] ||
                            r_ff.busy_cnt != '0) begin
                           nxt_r.st = DS_IDLE;
                           nxt_r.drv = 1'b0;
                        end
                     end
                     BY_INSTR: begin
                        nxt_r.instr = r_ff.sh;
                        op = r_ff.sh[OP_HI:OP_LO];
                        rsel = r_ff.sh[REG_HI:REG_LO];
                        pot = r_ff.sh[POT_BIT];
                        case (op)
                           OP_XFR_D2W: begin
                              nxt_r.wiper_position_register[pot] =
                                 r_ff.data_reg[pot][rsel];
                           end
                           OP_GXFR_D2W: begin
                              for (int p = 0; p < 2; p++) begin
                                 nxt_r.wiper_position_register[p] =
                                    r_ff.data_reg[p][rsel];
                              end
                           end
                           OP_XFR_W2D: begin
                              nxt_r.pend_pot = 2'b00;
                              nxt_r.pend_pot[pot] = 1'b1;
                              nxt_r.pend_reg = rsel;
                              nxt_r.pend_val =
                                 r_ff.wiper_position_register;
                           end
                           OP_GXFR_W2D: begin
                              nxt_r.pend_pot = 2'b11;
                              nxt_r.pend_reg = rsel;
                              nxt_r.pend_val =
                                 r_ff.wiper_position_register;
                           end
                           default: begin
                              if (!op_valid(op)) begin
                                 nxt_r.st = DS_IDLE;
                                 nxt_r.drv = 1'b0;
                              end
                           end
                        endcase
                     end
                     BY_DATA: begin
                        if (op == OP_WR_WCR) begin
                           nxt_r.wiper_position_register[pot] =
                              r_ff.sh[WIPER_BITS-1:0];
                        end else begin
                           nxt_r.pend_pot = 2'b00;
                           nxt_r.pend_pot[pot] = 1'b1;
                           nxt_r.pend_reg = rsel;
                           nxt_r.pend_val[pot] = r_ff.sh[WIPER_BITS-1:0];
                        end
                     end
                     default: begin
                        nxt_r.st = DS_IDLE;
                        nxt_r.drv = 1'b0;
                     end
                  endcase
               end
            end
            DS_ACK: begin
               // Hold the acknowledge across the whole ninth clock
               if (scl_rise) begin
                  nxt_r.ack_seen = 1'b1;
               end else if (scl_fall && r_ff.ack_seen) begin
                  nxt_r.drv = 1'b0;
                  nxt_r.cnt = '0;
                  nxt_r.st = DS_IDLE;
                  case (r_ff.by)
                     BY_ADDR: begin
                        nxt_r.st = DS_RX;
                        nxt_r.by = BY_INSTR;
                     end
                     BY_INSTR: begin
                        if (op == OP_WR_WCR || op == OP_WR_DR) begin
                           nxt_r.st = DS_RX;
                           nxt_r.by = BY_DATA;
                        end else if (op == OP_STEP) begin
                           nxt_r.st = DS_STEP;
                        end else if (op == OP_RD_WCR || op == OP_RD_DR) begin
                           val = (op == OP_RD_WCR) ?
                              r_ff.wiper_position_register[pot] :
                              r_ff.data_reg[pot][rsel];
                           // Open drain: a zero bit enables the driver
                           nxt_r.drv = ~val[WIPER_BITS-1];
                           nxt_r.sh = {val, 2'b00};
                           nxt_r.cnt = BIT_FIRST;
                           nxt_r.st = DS_TX;
                        end
                     end
                     default: nxt_r.st = DS_IDLE;
                  endcase
               end
            end
            DS_TX: begin
               if (scl_fall) begin
                  if (r_ff.cnt == BIT_LAST) begin
                     // Release for the master's acknowledge bit
                     nxt_r.drv = 1'b0;
                     nxt_r.st = DS_IDLE;
                  end else begin
                     // Bit 7 already went out at the acknowledge's end
                     nxt_r.drv = ~r_ff.sh[6];
                     nxt_r.sh = {r_ff.sh[6:0], 1'b0};
                     nxt_r.cnt = r_ff.cnt + 4'h1;
                  end
               end
            end
            DS_STEP: begin
               // Saturate at the array ends rather than wrap
               if (scl_rise) begin
                  if (r_ff.sda_s[1] &&
                      r_ff.wiper_position_register[pot] != WIPER_MAX) begin
                     nxt_r.wiper_position_register[pot] =
                        r_ff.wiper_position_register[pot] + 6'h01;
                  end else if (!r_ff.sda_s[1] &&
                      r_ff.wiper_position_register[pot] != WIPER_MIN) begin
                     nxt_r.wiper_position_register[pot] =
                        r_ff.wiper_position_register[pot] - 6'h01;
                  end
               end
            end
            default: begin
               nxt_r.st = DS_IDLE;
               nxt_r.drv = 1'b0;
            end
         endcase
      end

      for (int p = 0; p < 2; p++) begin
         nxt_r.tap[p] = TAP_ONE << nxt_r.wiper_position_register[p];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_ff <= '0;
         r_ff.scl_s <= 2'b11;
         r_ff.sda_s <= 2'b11;
         r_ff.scl_d <= 1'b1;
         r_ff.sda_d <= 1'b1;
         r_ff.wp_s <= 2'b00;
         r_ff.st <= DS_IDLE;
         r_ff.by <= BY_ADDR;
         r_ff.wiper_position_register <= {2{WIPER_RST}};
         r_ff.tap <= {2{TAP_ONE}};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = r_ff.drv;
   assign tap_sel_0 = r_ff.tap[0];
   assign tap_sel_1 = r_ff.tap[1];
   assign nv_busy = (r_ff.busy_cnt != '0);

endmodule

// *** hw/pot_host.sv ***
// Master end of the two-wire link: one transaction per request
`timescale 1ns/10ps
module pot_host
   import pot_link_pkg::*;
#(
   parameter int QTR = QTR_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   pot_link_if.host_end link,
   input wire logic req_valid,
   output logic req_ready,
   input wire host_mode_e req_mode,
   input wire logic [3:0] req_dev_addr,
   input wire logic [7:0] req_instr,
   input wire logic [7:0] req_wdata,
   output logic rsp_done,
   output logic rsp_ack_ok,
   output logic [7:0] rsp_rdata
);

   // Device samples the wires through two flops, so each clock phase
   // must last at least two cycles
   if (QTR < 2 || QTR > 255) begin : g_chk
      $error("QTR out of range");
   end

   localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

   typedef struct packed {
      host_state_e st;
      host_mode_e mode;
      logic [1:0] ph;
      logic [7:0] qcnt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [1:0] bytei;
      logic [7:0] instr;
      logic [7:0] wdata;
      logic [1:0] sda_s;
      logic scl;
      logic oe;
      logic ok;
      logic done;
      logic [7:0] rdata;
   } host_s;

   host_s r_ff;
   host_s nxt_r;

   always_comb begin
      logic tick;
      tick = (r_ff.qcnt == QTR_LAST);
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      nxt_r.sda_s = {r_ff.sda_s[0], link.sda};
      nxt_r.qcnt = tick ? 8'h00 : r_ff.qcnt + 8'h01;
      if (tick && r_ff.st != HS_IDLE) begin
         nxt_r.ph = r_ff.ph + 2'b01;
      end
      case (r_ff.st)
         HS_IDLE: begin
            nxt_r.scl = 1'b1;
            nxt_r.oe = 1'b0;
            if (req_valid) begin
               nxt_r.st = HS_START;
               nxt_r.mode = req_mode;
               nxt_r.instr = req_instr;
               nxt_r.wdata = req_wdata;
               nxt_r.sh = {DEV_TYPE_ID, req_dev_addr};
               nxt_r.ph = 2'b00;
               nxt_r.qcnt = 8'h00;
               nxt_r.bitn = '0;
               nxt_r.bytei = 2'b00;
               nxt_r.ok = 1'b1;
            end
         end
         HS_START: begin
            if (tick) begin
               case (r_ff.ph)
                  2'b00: nxt_r.oe = 1'b1;
                  2'b01: begin
                     nxt_r.scl = 1'b0;
                     nxt_r.st = HS_WBIT;
                     nxt_r.ph = 2'b00;
                  end
                  default: nxt_r.ph = 2'b01;
               endcase
            end
         end
         HS_WBIT: begin
            if (tick) begin
               case (r_ff.ph)
                  2'b00: nxt_r.oe = (r_ff.bitn != BIT_LAST) & ~r_ff.sh[7];
                  2'b01: nxt_r.scl = 1'b1;
                  2'b10: begin
                     if (r_ff.bitn == BIT_LAST && r_ff.sda_s[1]) begin
                        nxt_r.ok = 1'b0;
                     end
                  end
                  default: begin
                     nxt_r.scl = 1'b0;
                     nxt_r.bitn = r_ff.bitn + 4'h1;
                     nxt_r.sh = {r_ff.sh[6:0], 1'b0};
                     if (r_ff.bitn == BIT_LAST) begin
                        nxt_r.bitn = '0;
                        nxt_r.bytei = r_ff.bytei + 2'b01;
                        nxt_r.st = HS_STOP;
                        if (r_ff.ok && r_ff.mode != HM_POLL) begin
                           if (r_ff.bytei == 2'b00) begin
                              nxt_r.sh = r_ff.instr;
                              nxt_r.st = HS_WBIT;
                           end else if (r_ff.bytei == 2'b01) begin
                              if (r_ff.mode == HM_WRITE) begin
                                 nxt_r.sh = r_ff.wdata;
                                 nxt_r.st = HS_WBIT;
                              end else if (r_ff.mode == HM_READ) begin
                                 nxt_r.st = HS_RBIT;
                              end
                           end
                        end
                     end
                  end
               endcase
            end
         end
         HS_RBIT: begin
            if (tick) begin
               case (r_ff.ph)
                  2'b00: nxt_r.oe = 1'b0;
                  2'b01: nxt_r.scl = 1'b1;
                  2'b10: begin
                     if (r_ff.bitn != BIT_LAST) begin
                        nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s[1]};
                     end
                  end
                  default: begin
                     // Ninth bit left released: a single-byte read ends
                     nxt_r.scl = 1'b0;
                     nxt_r.bitn = r_ff.bitn + 4'h1;
                     if (r_ff.bitn == BIT_LAST) begin
                        nxt_r.rdata = r_ff.sh;
                        nxt_r.st = HS_STOP;
                     end
                  end
               endcase
            end
         end
         HS_STOP: begin
            if (tick) begin
               case (r_ff.ph)
                  2'b00: nxt_r.oe = 1'b1;
                  2'b01: nxt_r.scl = 1'b1;
                  2'b10: nxt_r.oe = 1'b0;
                  default: begin
                     nxt_r.st = HS_IDLE;
                     nxt_r.done = 1'b1;
                  end
               endcase
            end
         end
         default: nxt_r.st = HS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_ff <= '0;
         r_ff.st <= HS_IDLE;
         r_ff.mode <= HM_XFER;
         r_ff.sda_s <= 2'b11;
         r_ff.scl <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign link.scl = r_ff.scl;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = r_ff.oe;
   assign req_ready = (r_ff.st == HS_IDLE);
   assign rsp_done = r_ff.done;
   assign rsp_ack_ok = r_ff.ok;
   assign rsp_rdata = r_ff.rdata;

endmodule

// *** hw/pot_link_if.sv ***
// Two-wire link between bus master and potentiometer device
`timescale 1ns/10ps
interface pot_link_if;
   logic scl;
   logic sda;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_host_o;
   logic sda_host_oe;

   // Open-drain wire with pull-up: low when any enabled driver drives 0
   assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

   modport dev_end (
      input scl,
      input sda,
      output sda_dev_o,
      output sda_dev_oe
   );
   modport host_end (
      output scl,
      input sda,
      output sda_host_o,
      output sda_host_oe
   );
endinterface

// *** hw/pot_link_pkg.sv ***
// Shared constants and types for the two-wire potentiometer link
package pot_link_pkg;

   // Device-type identifier in the upper address nibble; value is arbitrary
   localparam logic [3:0] DEV_TYPE_ID = 4'ha;

   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h1;

   // Byte field positions
   localparam int ID_HI = 7;
   localparam int ID_LO = 4;
   localparam int ADR_HI = 3;
   localparam int ADR_LO = 0;
   localparam int OP_HI = 7;
   localparam int OP_LO = 4;
   localparam int REG_HI = 3;
   localparam int REG_LO = 2;
   localparam int POT_BIT = 0;
   localparam int WIPER_BITS = 6;

   // Instruction codes
   localparam logic [3:0] OP_RD_WCR = 4'h9;
   localparam logic [3:0] OP_WR_WCR = 4'ha;
   localparam logic [3:0] OP_RD_DR = 4'hb;
   localparam logic [3:0] OP_WR_DR = 4'hc;
   localparam logic [3:0] OP_XFR_D2W = 4'hd;
   localparam logic [3:0] OP_XFR_W2D = 4'he;
   localparam logic [3:0] OP_GXFR_D2W = 4'h1;
   localparam logic [3:0] OP_GXFR_W2D = 4'h8;
   localparam logic [3:0] OP_STEP = 4'h2;

   localparam logic [5:0] WIPER_MIN = 6'h00;
   localparam logic [5:0] WIPER_MAX = 6'h3f;
   localparam logic [5:0] WIPER_RST = 6'h00;
   localparam logic [63:0] TAP_ONE = 64'h1;

   // Timing
   localparam int CLK_KHZ = 25000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_WR_US = 5000;
   localparam int WR_CYC = T_WR_US * CLK_KHZ / 1000;
   localparam int SCL_PERIOD_NS = 320;
   localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int BUSY_W = 17;

   typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_STEP}
      dev_state_e;
   typedef enum logic [1:0] {BY_ADDR, BY_INSTR, BY_DATA} byte_e;
   typedef enum logic [2:0] {HS_IDLE, HS_START, HS_WBIT, HS_RBIT, HS_STOP}
      host_state_e;
   typedef enum logic [1:0] {HM_XFER, HM_WRITE, HM_READ, HM_POLL}
      host_mode_e;

endpackage

// *** sim/pot_link_sva.sv ***
// Concurrent checks on the two-wire potentiometer link
`timescale 1ns/10ps
module pot_link_sva #(
   parameter int WRITE_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_oe,
   input wire logic sda_host_oe,
   input wire logic nv_busy,
   input wire logic write_protect_b,
   input wire logic [63:0] tap_sel_0,
   input wire logic [63:0] tap_sel_1
);
   // Busy run is far too long for a repetition, so it is counted
   int busy_len_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_len_ff <= 0;
      end else begin
         busy_len_ff <= nv_busy ? busy_len_ff + 1 : 0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_dev_edge_low: assert property (
      $changed(sda_dev_oe) |-> !scl && !$past(scl))
      else $error("device data changed with clock high");
   a_one_driver: assert property (
      scl && sda_dev_oe |-> !sda_host_oe)
      else $error("host still drives while device answers");
   a_host_start: assert property (
      $fell(sda) && scl |-> sda_host_oe)
      else $error("start not made by the host");
   a_busy_quiet: assert property (
      nv_busy |-> !sda_dev_oe)
      else $error("device drives data while write busy");
   a_busy_len: assert property (
      $fell(nv_busy) |-> busy_len_ff == WRITE_CYCLES)
      else $error("write cycle length wrong");
   a_busy_after_stop: assert property (
      $rose(nv_busy) |-> scl && sda)
      else $error("write cycle began with bus not idle");
   a_busy_protect: assert property (
      $rose(nv_busy) |-> write_protect_b)
      else $error("write cycle began while protected");
   a_tap_onehot: assert property (
      $onehot(tap_sel_0) && $onehot(tap_sel_1))
      else $error("tap select not one-hot");
   c_busy: cover property ($rose(nv_busy));
   c_dev_ack: cover property ($rose(sda_dev_oe) ##[1:40] scl);
   c_start: cover property ($fell(sda) && scl);
endmodule

// *** sim/two_wire_pot_slave_interface_tb.sv ***
// Self-checking bench joining host and device ends of the link
`timescale 1ns/10ps
module two_wire_pot_slave_interface_tb;
   import pot_link_pkg::*;
   // Long enough that a poll reaches its ack while still busy
   localparam int WC = 400;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   host_mode_e req_mode = HM_POLL;
   logic [3:0] req_dev_addr = 4'h6;
   logic [7:0] req_instr = 8'h00;
   logic [7:0] req_wdata = 8'h00;
   logic [3:0] straps = 4'h6;
   logic wp_b = 1'b1;
   logic req_ready, rsp_done, rsp_ack_ok, nv_busy;
   logic [7:0] rsp_rdata;
   logic [63:0] tap_sel_0, tap_sel_1;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   pot_link_if link ();
   pot_dev #(.WRITE_CYCLES(WC)) pot_dev_i (.core_clk(core_clk),
      .rst_b(rst_b), .link(link), .board_address_straps(straps),
      .write_protect_b(wp_b), .tap_sel_0(tap_sel_0),
      .tap_sel_1(tap_sel_1), .nv_busy(nv_busy));
   pot_host #(.QTR(2)) pot_host_i (.core_clk(core_clk), .rst_b(rst_b),
      .link(link), .req_valid(req_valid), .req_ready(req_ready),
      .req_mode(req_mode), .req_dev_addr(req_dev_addr),
      .req_instr(req_instr), .req_wdata(req_wdata), .rsp_done(rsp_done),
      .rsp_ack_ok(rsp_ack_ok), .rsp_rdata(rsp_rdata));
   pot_link_sva #(.WRITE_CYCLES(WC)) pot_link_sva_i (.core_clk(core_clk),
      .rst_b(rst_b), .scl(link.scl), .sda(link.sda),
      .sda_dev_oe(link.sda_dev_oe), .sda_host_oe(link.sda_host_oe),
      .nv_busy(nv_busy), .write_protect_b(wp_b), .tap_sel_0(tap_sel_0),
      .tap_sel_1(tap_sel_1));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 12000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] ins(logic [3:0] op, logic [1:0] r,
      logic p);
      return {op, r, 1'b0, p};
   endfunction
   task automatic xfer(host_mode_e m, logic [7:0] i, logic [7:0] d);
      int n;
      @(negedge core_clk);
      req_mode = m;
      req_instr = i;
      req_wdata = d;
      req_valid = 1'b1;
      @(negedge core_clk);
      req_valid = 1'b0;
      for (n = 0; n < 3000 && rsp_done !== 1'b1; n++) @(negedge core_clk);
      check("transfer done", 64'h1, rsp_done);
      @(negedge core_clk);
      check("ready", 64'h1, req_ready);
   endtask
   initial begin
      int n;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      xfer(HM_WRITE, ins(OP_WR_WCR, 2'h0, 1'b0), 8'h15);
      check("ack write wiper", 64'h1, rsp_ack_ok);
      check("tap 0", TAP_ONE << 21, tap_sel_0);
      xfer(HM_READ, ins(OP_RD_WCR, 2'h0, 1'b0), 8'h00);
      check("read wiper", 64'h15, rsp_rdata[7:2]);
      $display("test wiper done");
      req_dev_addr = 4'h7;
      xfer(HM_POLL, 8'h00, 8'h00);
      check("ack wrong strap", 64'h0, rsp_ack_ok);
      req_dev_addr = 4'h6;
      $display("test address done");
      xfer(HM_WRITE, ins(OP_WR_DR, 2'h2, 1'b1), 8'h2a);
      check("ack write data reg", 64'h1, rsp_ack_ok);
      xfer(HM_POLL, 8'h00, 8'h00);
      check("busy", 64'h1, nv_busy);
      check("ack poll busy", 64'h0, rsp_ack_ok);
      for (n = 0; n < WC && nv_busy !== 1'b0; n++) @(negedge core_clk);
      check("busy ended", 64'h0, nv_busy);
      xfer(HM_POLL, 8'h00, 8'h00);
      check("ack poll done", 64'h1, rsp_ack_ok);
      xfer(HM_XFER, ins(OP_XFR_D2W, 2'h2, 1'b1), 8'h00);
      check("tap 1 copy", TAP_ONE << 42, tap_sel_1);
      $display("test nv write done");
      wp_b = 1'b0;
      xfer(HM_WRITE, ins(OP_WR_DR, 2'h2, 1'b1), 8'h05);
      repeat (6) @(negedge core_clk);
      check("busy protected", 64'h0, nv_busy);
      wp_b = 1'b1;
      xfer(HM_READ, ins(OP_RD_DR, 2'h2, 1'b1), 8'h00);
      check("data reg kept", 64'h2a, rsp_rdata[7:2]);
      xfer(HM_WRITE, ins(OP_WR_WCR, 2'h0, 1'b1), 8'h3f);
      check("tap 1 top", TAP_ONE << 63, tap_sel_1);
      $display("test protect done");
      xfer(HM_XFER, ins(OP_GXFR_D2W, 2'h2, 1'b0), 8'h00);
      check("tap 0 global", TAP_ONE, tap_sel_0);
      check("tap 1 global", TAP_ONE << 42, tap_sel_1);
      $display("test global copy done");
      conclude();
   end
endmodule
